// ==== core/counter_array_watchdog_defines.svh ====
// register addresses, field positions, reset values and divider counts
// assumes an 8-bit special function register space
`ifndef COUNTER_ARRAY_WATCHDOG_DEFINES_SVH
`define COUNTER_ARRAY_WATCHDOG_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define ADDR_CONTROL_STATUS 8'hd8
`define ADDR_MODE 8'hd9
`define ADDR_COUNTER_LOW 8'he9
`define ADDR_COUNTER_HIGH 8'hf9
`define ADDR_MODULE2_UPDATE_OFFSET 8'hed
`define ADDR_MODULE2_COMPARE_HIGH 8'hfd
`define ADDR_MODULE2_MODE 8'hdc

// ----------------------------------------------------------------------------
// control/status fields
// ----------------------------------------------------------------------------
`define CS_OVERFLOW_BIT 7
`define CS_RUN_BIT 6
`define CS_MODULE2_BIT 2
`define CS_MODULE1_BIT 1
`define CS_MODULE0_BIT 0

// ----------------------------------------------------------------------------
// mode fields
// ----------------------------------------------------------------------------
`define MODE_IDLE_BIT 7
`define MODE_ENABLE_BIT 6
`define MODE_LOCK_BIT 5
`define MODE_SRC_HI 3
`define MODE_SRC_LO 1
`define MODE_OVF_IE_BIT 0

// ----------------------------------------------------------------------------
// reset values and timebase counts
// ----------------------------------------------------------------------------
`define RESET_CONTROL_STATUS 8'h00
`define RESET_MODE 8'h40
`define RESET_BYTE 8'h00
`define DIV_SLOW 4'd12
`define DIV_FAST 4'd4
`define DIV_EXT 3'd7

`endif

// ==== core/counter_array_watchdog_pkg.sv ====
// types of the counter array watchdog
// assumes the defines header is compiled alongside
package counter_array_watchdog_pkg;

    typedef enum logic [2:0]
    {
        SRC_SYS_DIV12 = 3'b000,
        SRC_SYS_DIV4 = 3'b001,
        SRC_TIMER0 = 3'b010,
        SRC_EXT_FALL = 3'b011,
        SRC_SYS = 3'b100,
        SRC_EXT_DIV8 = 3'b101
    } clock_source_t;

    typedef struct packed
    {
        logic counter_overflow_flag;
        logic counter_run_control;
        logic [2:0] match_flag;
        logic idle_suspend_bit;
        logic watchdog_enable_bit;
        logic watchdog_lock_bit;
        logic [2:0] counter_clock_source_select;
        logic overflow_irq_enable;
        logic [7:0] counter_low_byte;
        logic [7:0] counter_high_byte;
        logic [7:0] module2_update_offset;
        logic [7:0] module2_compare_high;
        logic [7:0] module2_mode_register;
        logic [3:0] prescale;
        logic [2:0] ext_div;
        logic [2:0] count_sync;
        logic [2:0] ext_clk_sync;
        logic count_level;
        logic ext_clk_level;
        logic watchdog_reset_request;
        logic [7:0] sfr_rdata;
    } state_t;

endpackage : counter_array_watchdog_pkg

// ==== core/counter_array_watchdog.sv ====
// counter array with watchdog on compare module 2, plus control/status register
// assumes a single-cycle sfr write/read strobe from the processor on clk_sys
`timescale 1ns/1ps
`include "counter_array_watchdog_defines.svh"

module counter_array_watchdog
    import counter_array_watchdog_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    input wire logic [2:0] module_event,
    input wire logic [2:0] module_irq_enable,
    output logic counter_array_irq,
    output logic watchdog_reset_request
);

    state_t cur;
    state_t next_state;

    logic enabled;
    logic tick;
    logic low_wrap;
    logic [15:0] count;

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_state = cur;
        enabled = cur.watchdog_enable_bit | cur.watchdog_lock_bit;
        count = {cur.counter_high_byte, cur.counter_low_byte};

        // pin inputs: a change counts once the second and third stages agree
        next_state.count_sync = {cur.count_sync[1:0], external_count_input};
        next_state.ext_clk_sync = {cur.ext_clk_sync[1:0], external_clock};
        if (cur.count_sync[2] == cur.count_sync[1])
        begin
            next_state.count_level = cur.count_sync[2];
        end
        if (cur.ext_clk_sync[2] == cur.ext_clk_sync[1])
        begin
            next_state.ext_clk_level = cur.ext_clk_sync[2];
        end

        // prescaler runs freely so the timebase phase is independent of run control
        if (cur.prescale == `DIV_SLOW - 4'd1)
        begin
            next_state.prescale = 4'd0;
        end
        else
        begin
            next_state.prescale = cur.prescale + 4'd1;
        end
        if (cur.ext_clk_level & ~next_state.ext_clk_level)
        begin
            next_state.ext_div = cur.ext_div + 3'd1;
        end

        case (clock_source_t'(cur.counter_clock_source_select))
            SRC_SYS_DIV12: tick = (cur.prescale == `DIV_SLOW - 4'd1);
            SRC_SYS_DIV4: tick = (cur.prescale[1:0] == 2'd3);
            SRC_TIMER0: tick = timer0_overflow;
            SRC_EXT_FALL: tick = cur.count_level & ~next_state.count_level;
            SRC_SYS: tick = 1'b1;
            SRC_EXT_DIV8: tick = cur.ext_clk_level & ~next_state.ext_clk_level
                & (cur.ext_div == `DIV_EXT);
            default: tick = 1'b0;
        endcase
        // watchdog forces the counter on; idle suspend can still hold it
        tick = tick & (cur.counter_run_control | enabled)
            & ~(cur.idle_suspend_bit & cpu_idle);
        low_wrap = tick & (cur.counter_low_byte == 8'hff);

        // ------------------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------------------
        if (sfr_wr)
        begin
            case (sfr_addr)
                `ADDR_CONTROL_STATUS:
                begin
                    // bits 5..3 have no storage
                    next_state.counter_overflow_flag = sfr_wdata[`CS_OVERFLOW_BIT];
                    next_state.counter_run_control = sfr_wdata[`CS_RUN_BIT];
                    next_state.match_flag = sfr_wdata[`CS_MODULE2_BIT:`CS_MODULE0_BIT];
                end
                `ADDR_MODE:
                begin
                    if (enabled)
                    begin
                        // only lock and enable may change; enable cannot fall under lock
                        next_state.watchdog_lock_bit = 1'b1 & (cur.watchdog_lock_bit
                            | sfr_wdata[`MODE_LOCK_BIT]);
                        next_state.watchdog_enable_bit = sfr_wdata[`MODE_ENABLE_BIT]
                            | cur.watchdog_lock_bit | sfr_wdata[`MODE_LOCK_BIT];
                    end
                    else
                    begin
                        next_state.idle_suspend_bit = sfr_wdata[`MODE_IDLE_BIT];
                        next_state.watchdog_enable_bit = sfr_wdata[`MODE_ENABLE_BIT]
                            | sfr_wdata[`MODE_LOCK_BIT];
                        next_state.watchdog_lock_bit = sfr_wdata[`MODE_LOCK_BIT];
                        next_state.counter_clock_source_select =
                            sfr_wdata[`MODE_SRC_HI:`MODE_SRC_LO];
                        next_state.overflow_irq_enable = sfr_wdata[`MODE_OVF_IE_BIT];
                    end
                end
                `ADDR_COUNTER_LOW:
                begin
                    if (!enabled)
                    begin
                        next_state.counter_low_byte = sfr_wdata;
                    end
                end
                `ADDR_COUNTER_HIGH:
                begin
                    if (!enabled)
                    begin
                        next_state.counter_high_byte = sfr_wdata;
                    end
                end
                `ADDR_MODULE2_UPDATE_OFFSET:
                begin
                    next_state.module2_update_offset = sfr_wdata;
                end
                `ADDR_MODULE2_COMPARE_HIGH:
                begin
                    if (enabled)
                    begin
                        // service: deadline lands offset high-byte steps ahead
                        next_state.module2_compare_high = cur.counter_high_byte
                            + cur.module2_update_offset;
                    end
                    else
                    begin
                        next_state.module2_compare_high = sfr_wdata;
                    end
                end
                `ADDR_MODULE2_MODE:
                begin
                    if (!enabled)
                    begin
                        next_state.module2_mode_register = sfr_wdata;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // ------------------------------------------------------------------------
        // counting; counter beats any firmware counter write in the same cycle
        // ------------------------------------------------------------------------
        if (tick)
        begin
            {next_state.counter_high_byte, next_state.counter_low_byte} = count + 16'd1;
        end

        // hardware sets win over a firmware clear in the same cycle
        if (tick && count == 16'hffff)
        begin
            next_state.counter_overflow_flag = 1'b1;
        end
        next_state.match_flag = next_state.match_flag | module_event;

        // one pulse per event; the reset controller acts on it at once
        next_state.watchdog_reset_request = enabled & ((low_wrap
            & (cur.module2_compare_high == cur.counter_high_byte))
            | (sfr_wr & (sfr_addr == `ADDR_CONTROL_STATUS)
            & sfr_wdata[`CS_MODULE2_BIT]));

        // ------------------------------------------------------------------------
        // read data, registered on the read strobe
        // ------------------------------------------------------------------------
        next_state.sfr_rdata = 8'h00;
        if (sfr_rd)
        begin
            case (sfr_addr)
                `ADDR_CONTROL_STATUS: next_state.sfr_rdata = {cur.counter_overflow_flag,
                    cur.counter_run_control, 3'b000, cur.match_flag};
                `ADDR_MODE: next_state.sfr_rdata = {cur.idle_suspend_bit,
                    cur.watchdog_enable_bit, cur.watchdog_lock_bit, 1'b0,
                    cur.counter_clock_source_select, cur.overflow_irq_enable};
                `ADDR_COUNTER_LOW: next_state.sfr_rdata = cur.counter_low_byte;
                `ADDR_COUNTER_HIGH: next_state.sfr_rdata = cur.counter_high_byte;
                `ADDR_MODULE2_UPDATE_OFFSET: next_state.sfr_rdata = cur.module2_update_offset;
                `ADDR_MODULE2_COMPARE_HIGH: next_state.sfr_rdata = cur.module2_compare_high;
                `ADDR_MODULE2_MODE: next_state.sfr_rdata = cur.module2_mode_register;
                default: next_state.sfr_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.watchdog_enable_bit <= 1'b1;
            cur.counter_clock_source_select <= 3'b000;
            cur.counter_low_byte <= `RESET_BYTE;
            cur.module2_update_offset <= `RESET_BYTE;
        end
        else
        begin
            cur <= next_state;
        end
    end

    assign sfr_rdata = cur.sfr_rdata;
    assign watchdog_reset_request = cur.watchdog_reset_request;
    assign counter_array_irq = (cur.counter_overflow_flag & cur.overflow_irq_enable)
        | (|(cur.match_flag & module_irq_enable));

endmodule : counter_array_watchdog

// ==== tb/counter_array_watchdog_asserts.sv ====
// port-level checker for the counter array watchdog
// assumes one clk_sys domain and the design's defines header
`timescale 1ns/1ps
`include "counter_array_watchdog_defines.svh"

module counter_array_watchdog_checker
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [2:0] module_event,
    input wire logic [2:0] module_irq_enable,
    input wire logic counter_array_irq,
    input wire logic watchdog_reset_request
);
    logic en;
    logic lock;
    logic untouched;
    logic [15:0] cycles;

    // shadow of enable and lock, only mode writes move them
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            en <= 1'b1;
            lock <= 1'b0;
            untouched <= 1'b1;
            cycles <= 16'h0000;
        end
        else
        begin
            cycles <= cycles + 16'h0001;
            if (sfr_wr)
                untouched <= 1'b0;
            if (sfr_wr && sfr_addr == `ADDR_MODE && !lock)
            begin
                lock <= sfr_wdata[`MODE_LOCK_BIT];
                en <= sfr_wdata[`MODE_LOCK_BIT] | sfr_wdata[`MODE_ENABLE_BIT];
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_single_pulse: assert property (watchdog_reset_request |=> !watchdog_reset_request)
        else $error("reset request longer than one cycle");
    a_forced_reset: assert property (sfr_wr && sfr_addr == `ADDR_CONTROL_STATUS
        && sfr_wdata[`CS_MODULE2_BIT] && en |=> watchdog_reset_request)
        else $error("forced reset request missing");
    a_request_enabled: assert property (watchdog_reset_request |-> $past(en))
        else $error("reset request while watchdog disabled");
    a_default_timeout: assert property (watchdog_reset_request && untouched |-> cycles == 16'd3072)
        else $error("default timeout at wrong cycle");
    a_unused_bits: assert property (sfr_rd && sfr_addr == `ADDR_CONTROL_STATUS |=> sfr_rdata[5:3] == 3'b000)
        else $error("control bits 5 to 3 not zero");
    a_idle_rdata: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero without read");
    a_module_irq: assert property (module_event[0] && module_irq_enable[0]
        |=> counter_array_irq || !module_irq_enable[0])
        else $error("module flag interrupt missing");
    a_lock_holds: assert property (sfr_rd && sfr_addr == `ADDR_MODE && lock
        |=> sfr_rdata[`MODE_ENABLE_BIT] && sfr_rdata[`MODE_LOCK_BIT])
        else $error("locked watchdog not enabled");

    c_request: cover property (watchdog_reset_request);
    c_irq: cover property (counter_array_irq);
    c_locked_read: cover property (sfr_rd && lock);
endmodule : counter_array_watchdog_checker

bind counter_array_watchdog counter_array_watchdog_checker chk_u (.clk_sys(clk_sys), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .module_event(module_event), .module_irq_enable(module_irq_enable),
    .counter_array_irq(counter_array_irq), .watchdog_reset_request(watchdog_reset_request));

// ==== tb/tick_source.sv ====
// timer 0 overflow pulses and external pins from the rest of the chip
// assumes the bench raises run only while timer 0 should tick the counter
`timescale 1ns/1ps

module tick_source
(
    input wire logic clk_sys,
    input wire logic run,
    output logic timer0_overflow,
    output logic external_count_input,
    output logic external_clock,
    output int ticks
);
    logic [1:0] phase;

    // pins idle high, as if pulled up
    assign external_count_input = 1'b1;
    assign external_clock = 1'b1;
    initial
    begin
        phase = 2'h0;
        ticks = 0;
        timer0_overflow = 1'b0;
    end
    always @(posedge clk_sys)
    begin
        phase <= phase + 2'h1;
        timer0_overflow <= #1 run && phase == 2'h3;
        if (run && phase == 2'h3)
            ticks <= ticks + 1;
    end
endmodule : tick_source

// ==== tb/counter_array_watchdog_tb_top.sv ====
// self-checking bench: register access sequences with expected values
// assumes the design, its checker and tick_source are compiled first
`timescale 1ns/1ps
`include "counter_array_watchdog_defines.svh"

module counter_array_watchdog_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [2:0] module_event = 3'h0;
    logic [2:0] module_irq_enable = 3'h0;
    logic counter_array_irq;
    logic watchdog_reset_request;
    logic timer0_overflow;
    logic external_count_input;
    logic external_clock;
    logic run = 1'b0;
    logic cpu_idle = 1'b0;
    int ticks;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    counter_array_watchdog dut_u (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input), .external_clock(external_clock),
        .module_event(module_event), .module_irq_enable(module_irq_enable),
        .counter_array_irq(counter_array_irq), .watchdog_reset_request(watchdog_reset_request));
    tick_source partner_u (.clk_sys(clk_sys), .run(run), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input), .external_clock(external_clock),
        .ticks(ticks));

    initial forever #2 clk_sys = ~clk_sys;

    // whole run is near 5200 cycles; a hang ends at cycle 20000, well above this
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic compare(input string what, input logic [15:0] expected, input logic [15:0] seen);
        checked++;
        if (seen !== expected)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, expected, seen);
        end
    endtask : compare

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_wr = 1'b0;
    endtask : write_reg

    task automatic check_reg(input string what, input logic [7:0] addr, input logic [7:0] expected);
        @(posedge clk_sys);
        #1;
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_rd = 1'b0;
        compare(what, {8'h00, expected}, {8'h00, sfr_rdata});
    endtask : check_reg

    task automatic wait_request(input int limit);
        int n;
        n = 0;
        while (watchdog_reset_request !== 1'b1 && n < limit)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        compare("reset request", 16'h0001, {15'h0000, watchdog_reset_request});
    endtask : wait_request

    task automatic apply_reset();
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
    endtask : apply_reset

    task automatic conclude();
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    initial
    begin
        apply_reset();
        check_reg("control", `ADDR_CONTROL_STATUS, `RESET_CONTROL_STATUS);
        check_reg("mode", `ADDR_MODE, `RESET_MODE);
        check_reg("offset", `ADDR_MODULE2_UPDATE_OFFSET, `RESET_BYTE);
        check_reg("unmapped", 8'h00, 8'h00);
        wait_request(3200);
        apply_reset();
        write_reg(`ADDR_MODE, 8'h00);
        check_reg("mode off", `ADDR_MODE, 8'h00);
        write_reg(`ADDR_MODULE2_UPDATE_OFFSET, 8'h01);
        write_reg(`ADDR_MODE, 8'h44);
        write_reg(`ADDR_MODE, 8'hc0);
        check_reg("mode frozen", `ADDR_MODE, 8'h44);
        write_reg(`ADDR_COUNTER_LOW, 8'h10);
        check_reg("low blocked", `ADDR_COUNTER_LOW, 8'h00);
        write_reg(`ADDR_MODULE2_COMPARE_HIGH, 8'h77);
        check_reg("compare", `ADDR_MODULE2_COMPARE_HIGH, 8'h01);
        run = 1'b1;
        wait_request(4000);
        run = 1'b0;
        compare("ticks", 16'd512, ticks[15:0]);
        write_reg(`ADDR_MODE, 8'h64);
        write_reg(`ADDR_MODE, 8'h00);
        check_reg("locked", `ADDR_MODE, 8'h64);
        write_reg(`ADDR_CONTROL_STATUS, 8'h04);
        compare("forced", 16'h0001, {15'h0000, watchdog_reset_request});
        apply_reset();
        // watchdog is enabled again after reset; clock source only moves once disabled
        write_reg(`ADDR_MODE, 8'h00);
        write_reg(`ADDR_MODE, 8'h89);
        check_reg("mode set", `ADDR_MODE, 8'h89);
        write_reg(`ADDR_COUNTER_LOW, 8'hfe);
        write_reg(`ADDR_COUNTER_HIGH, 8'hff);
        write_reg(`ADDR_CONTROL_STATUS, 8'h40);
        repeat (4) @(posedge clk_sys);
        check_reg("overflow", `ADDR_CONTROL_STATUS, 8'hc0);
        compare("irq on", 16'h0001, {15'h0000, counter_array_irq});
        write_reg(`ADDR_CONTROL_STATUS, 8'h38);
        check_reg("cleared", `ADDR_CONTROL_STATUS, 8'h00);
        compare("irq off", 16'h0000, {15'h0000, counter_array_irq});
        module_irq_enable = 3'b101;
        module_event = 3'b111;
        @(posedge clk_sys);
        #1;
        module_event = 3'b000;
        check_reg("flags", `ADDR_CONTROL_STATUS, 8'h07);
        compare("irq flags", 16'h0001, {15'h0000, counter_array_irq});
        write_reg(`ADDR_COUNTER_LOW, 8'h20);
        cpu_idle = 1'b1;
        write_reg(`ADDR_CONTROL_STATUS, 8'h40);
        repeat (4) @(posedge clk_sys);
        check_reg("idle hold", `ADDR_COUNTER_LOW, 8'h20);
        cpu_idle = 1'b0;
        conclude();
    end
endmodule : counter_array_watchdog_tb_top
